// *** rit_consts.svh ***
// Offsets, field positions, reset values and prescale masks of the refresh interval timer
`ifndef RIT_CONSTS_SVH
`define RIT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RIT_OFS_CNT 12'h000
`define RIT_OFS_COR 12'h004
`define RIT_OFS_CSR 12'h008
`define RIT_OFS_MCR 12'h00C
`define RIT_OFS_IST 12'h010
`define RIT_OFS_IMSK 12'h014

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RIT_CSR_MATCH_BIT 7
`define RIT_CSR_SEL_LSB 3
`define RIT_CSR_SEL_MSB 5
`define RIT_MCR_REFRESH_ENABLE_BIT 0
`define RIT_MCR_CBR_BIT 1
`define RIT_IRQ_MATCH_BIT 0
`define RIT_IRQ_REFRESH_BIT 1

// ----------------------------------------------------------------------
// Write key and reset values
// ----------------------------------------------------------------------
`define RIT_WRITE_KEY 8'hA5
`define RIT_RST_BYTE 8'h00
`define RIT_RST_SEL 3'h0
`define RIT_RST_MCR 2'h0
`define RIT_RST_IRQ 2'h0
`define RIT_RST_PRE 12'h000
`define RIT_RST_DATA 32'h00000000

// ----------------------------------------------------------------------
// Prescale masks (divide by mask + 1)
// ----------------------------------------------------------------------
`define RIT_MASK_DIV4 12'h003
`define RIT_MASK_DIV16 12'h00F
`define RIT_MASK_DIV64 12'h03F
`define RIT_MASK_DIV256 12'h0FF
`define RIT_MASK_DIV1024 12'h3FF
`define RIT_MASK_DIV2048 12'h7FF
`define RIT_MASK_DIV4096 12'hFFF

`endif

// *** rit_pkg.sv ***
// Types of the refresh interval timer
package rit_pkg;
  typedef logic [7:0] rit_byte_t;
  typedef logic [11:0] rit_addr_t;
  typedef logic [31:0] rit_word_t;
  typedef logic [11:0] rit_pre_t;
  typedef enum logic [2:0] {
    RIT_SEL_STOP,
    RIT_SEL_DIV4,
    RIT_SEL_DIV16,
    RIT_SEL_DIV64,
    RIT_SEL_DIV256,
    RIT_SEL_DIV1024,
    RIT_SEL_DIV2048,
    RIT_SEL_DIV4096
  } rit_sel_e;
endpackage : rit_pkg

// *** rit_timer.sv ***
// Refresh interval timer with APB register access
//
// How it works
// - Eight-bit up-counter in low byte of a sixteen-bit register, steps per tick.
// - Tick source chosen by the three-bit prescale select field of control/status.
// - Ticks from bus clock divided by 4..4096; select zero stops counting.
// - Interval constant compared with counter low byte on every cycle.
// - On equality set the interval match flag and clear the counter.
// - With refresh enabled in CBR mode, each match starts a refresh cycle.
// - Power-on reset clears the tick counter.
// - Counter holds its value in standby.
// - Power-on reset clears the constant; standby keeps it.
// - Counter, constant and control/status writes need sixteen-bit access with key A5 in the upper byte.
`timescale 1ns/100ps
`include "rit_consts.svh"

module rit_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire rit_pkg::rit_addr_t paddr,
  input wire rit_pkg::rit_word_t pwdata,
  input wire logic [3:0] pstrb,
  output rit_pkg::rit_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_bus_clock,
  input wire logic standby,
  output logic refresh_start,
  output logic irq
);
  import rit_pkg::*;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic rit_pre_t div_mask(input rit_sel_e sel);
    rit_pre_t m;
    m = `RIT_RST_PRE;
    unique case (sel)
      RIT_SEL_STOP: m = `RIT_RST_PRE;
      RIT_SEL_DIV4: m = `RIT_MASK_DIV4;
      RIT_SEL_DIV16: m = `RIT_MASK_DIV16;
      RIT_SEL_DIV64: m = `RIT_MASK_DIV64;
      RIT_SEL_DIV256: m = `RIT_MASK_DIV256;
      RIT_SEL_DIV1024: m = `RIT_MASK_DIV1024;
      RIT_SEL_DIV2048: m = `RIT_MASK_DIV2048;
      RIT_SEL_DIV4096: m = `RIT_MASK_DIV4096;
    endcase
    return m;
  endfunction : div_mask

  function automatic rit_word_t zext(input rit_byte_t b);
    return {24'h000000, b};
  endfunction : zext

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rit_byte_t refresh_tick_counter;
  rit_byte_t refresh_interval_constant;
  logic interval_match_flag;
  rit_sel_e tick_prescale_select;
  logic refresh_enable;
  logic cbr_mode;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  rit_pre_t prescale;
  logic [2:0] bclk_sync;
  logic bclk_level;
  logic standby_q;
  logic [2:0] stby_sync;
  logic match_q;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic setup_ph;
  logic wr_acc;
  logic keyed;
  logic wr_cnt;
  logic wr_cor;
  logic wr_csr;
  logic wr_mcr;
  logic wr_ist;
  logic wr_imsk;
  logic mapped;

  assign setup_ph = psel && !penable;
  assign wr_acc = pce && psel && penable && pready && pwrite;
  // Sixteen-bit lane pair plus key byte
  assign keyed = (pstrb[1:0] == 2'b11) && (pwdata[15:8] == `RIT_WRITE_KEY);
  assign wr_cnt = wr_acc && keyed && (paddr == `RIT_OFS_CNT);
  assign wr_cor = wr_acc && keyed && (paddr == `RIT_OFS_COR);
  assign wr_csr = wr_acc && keyed && (paddr == `RIT_OFS_CSR);
  assign wr_mcr = wr_acc && pstrb[0] && (paddr == `RIT_OFS_MCR);
  assign wr_ist = wr_acc && pstrb[0] && (paddr == `RIT_OFS_IST);
  assign wr_imsk = wr_acc && pstrb[0] && (paddr == `RIT_OFS_IMSK);
  assign mapped = (paddr == `RIT_OFS_CNT) || (paddr == `RIT_OFS_COR) ||
                  (paddr == `RIT_OFS_CSR) || (paddr == `RIT_OFS_MCR) ||
                  (paddr == `RIT_OFS_IST) || (paddr == `RIT_OFS_IMSK);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_sync <= 3'h0;
      stby_sync <= 3'h0;
    end else if (pce) begin
      bclk_sync <= {bclk_sync[1:0], external_bus_clock};
      stby_sync <= {stby_sync[1:0], standby};
    end
  end

  logic bclk_rise;
  assign bclk_rise = (bclk_sync[1] == bclk_sync[2]) && bclk_sync[2] && !bclk_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_level <= 1'b0;
      standby_q <= 1'b0;
    end else if (pce) begin
      if (bclk_sync[1] == bclk_sync[2]) begin
        bclk_level <= bclk_sync[2];
      end
      if (stby_sync[1] == stby_sync[2]) begin
        standby_q <= stby_sync[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  logic tick;
  rit_pre_t cur_mask;
  assign cur_mask = div_mask(tick_prescale_select);
  assign tick = bclk_rise && !standby_q && (tick_prescale_select != RIT_SEL_STOP) &&
                ((prescale & cur_mask) == cur_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= `RIT_RST_PRE;
    end else if (pce && bclk_rise && !standby_q) begin
      prescale <= prescale + 12'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Counter and compare
  // ----------------------------------------------------------------------
  logic match_now;
  logic match_evt;
  assign match_now = (refresh_tick_counter == refresh_interval_constant);
  assign match_evt = match_now && !match_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_tick_counter <= `RIT_RST_BYTE;
    end else if (pce) begin
      if (wr_cnt) begin
        refresh_tick_counter <= pwdata[7:0];
      end else if (match_now) begin
        refresh_tick_counter <= `RIT_RST_BYTE;
      end else if (tick) begin
        refresh_tick_counter <= refresh_tick_counter + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= 1'b0;
    end else if (pce) begin
      match_q <= match_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_interval_constant <= `RIT_RST_BYTE;
    end else if (pce && wr_cor) begin
      refresh_interval_constant <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Control/status and memory control
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_match_flag <= 1'b0;
      tick_prescale_select <= RIT_SEL_STOP;
    end else if (pce) begin
      if (wr_csr) begin
        tick_prescale_select <= rit_sel_e'(pwdata[`RIT_CSR_SEL_MSB:`RIT_CSR_SEL_LSB]);
      end
      // Writing one leaves the flag alone; a new match beats a clear
      if (match_evt) begin
        interval_match_flag <= 1'b1;
      end else if (wr_csr && !pwdata[`RIT_CSR_MATCH_BIT]) begin
        interval_match_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cbr_mode, refresh_enable} <= `RIT_RST_MCR;
    end else if (pce && wr_mcr) begin
      refresh_enable <= pwdata[`RIT_MCR_REFRESH_ENABLE_BIT];
      cbr_mode <= pwdata[`RIT_MCR_CBR_BIT];
    end
  end

  logic refresh_evt;
  assign refresh_evt = match_evt && refresh_enable && cbr_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_start <= 1'b0;
    end else if (pce) begin
      refresh_start <= refresh_evt;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  logic [1:0] irq_set;
  assign irq_set = {refresh_evt, match_evt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `RIT_RST_IRQ;
    end else if (pce) begin
      irq_status <= (irq_status & ~(wr_ist ? pwdata[1:0] : 2'b00)) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `RIT_RST_IRQ;
    end else if (pce && wr_imsk) begin
      irq_mask <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (pce) begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------
  rit_word_t rd_mux;
  always_comb begin
    rd_mux = `RIT_RST_DATA;
    if (paddr == `RIT_OFS_CNT) begin
      rd_mux = zext(refresh_tick_counter);
    end else if (paddr == `RIT_OFS_COR) begin
      rd_mux = zext(refresh_interval_constant);
    end else if (paddr == `RIT_OFS_CSR) begin
      rd_mux = zext({interval_match_flag, 1'b0, tick_prescale_select, 3'b000});
    end else if (paddr == `RIT_OFS_MCR) begin
      rd_mux = zext({6'h00, cbr_mode, refresh_enable});
    end else if (paddr == `RIT_OFS_IST) begin
      rd_mux = zext({6'h00, irq_status});
    end else if (paddr == `RIT_OFS_IMSK) begin
      rd_mux = zext({6'h00, irq_mask});
    end
  end

  // Answer is latched in the setup cycle, so every access has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RIT_RST_DATA;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (pce) begin
      pready <= setup_ph;
      pslverr <= setup_ph && !mapped;
      if (setup_ph && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    pce && tick && !match_now && !wr_cnt |=> refresh_tick_counter ==
      $past(refresh_tick_counter) + 8'h01)
    else $error("counter did not step on tick");

  a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
    pce && tick_prescale_select == RIT_SEL_STOP && !wr_cnt && !match_now
      |=> $stable(refresh_tick_counter))
    else $error("counter moved with select zero");

  a_div4_tick: assert property (@(posedge pclk) disable iff (!presetn)
    tick && tick_prescale_select == RIT_SEL_DIV4 |-> prescale[1:0] == 2'b11)
    else $error("divide by four tick at wrong phase");

  a_match_clear: assert property (@(posedge pclk) disable iff (!presetn)
    pce && match_now && !wr_cnt |=> refresh_tick_counter == 8'h00)
    else $error("counter not cleared on match");

  a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
    pce && match_now && !match_q |=> interval_match_flag && irq_status[0])
    else $error("match flag not set");

  a_refresh_go: assert property (@(posedge pclk) disable iff (!presetn)
    pce && $rose(interval_match_flag) && $past(refresh_enable) && $past(cbr_mode)
      |-> refresh_start)
    else $error("refresh not started on match");

  a_refresh_gate: assert property (@(posedge pclk) disable iff (!presetn)
    refresh_start |-> $past(refresh_enable) && $past(cbr_mode))
    else $error("refresh started while disabled");

  a_key_guard: assert property (@(posedge pclk) disable iff (!presetn)
    pce && wr_acc && paddr == `RIT_OFS_COR && !keyed
      |=> $stable(refresh_interval_constant))
    else $error("unkeyed write changed constant");

  a_key_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cor |=> refresh_interval_constant == $past(pwdata[7:0]))
    else $error("keyed write not taken");

  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && psel && penable &&
      (paddr == `RIT_OFS_CNT || paddr == `RIT_OFS_COR) |-> prdata[31:8] == 24'h000000)
    else $error("upper bits read nonzero");

  a_standby_hold: assert property (@(posedge pclk) disable iff (!presetn)
    pce && standby_q && !wr_cnt && !match_now |=> $stable(refresh_tick_counter))
    else $error("counter moved in standby");

endmodule : rit_timer

// *** rit_timer_test.sv ***
// Self-checking testbench of the refresh interval timer
`timescale 1ns/100ps
`include "rit_consts.svh"

module rit_timer_test;
  import rit_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  rit_addr_t paddr = '0;
  rit_word_t pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  rit_word_t prdata;
  logic pready;
  logic pslverr;
  logic refresh_start;
  logic irq;
  logic external_bus_clock = 1'b0;
  logic standby = 1'b0;
  logic ck_run = 1'b0;
  logic [2:0] ck_cnt = 3'h0;
  int bad_count = 0;
  int num_checks = 0;
  rit_word_t rd;
  rit_word_t rd2;
  logic err;

  rit_timer i_rit_timer (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_bus_clock(external_bus_clock), .standby(standby),
    .refresh_start(refresh_start), .irq(irq));

  always #5 pclk = ~pclk;

  // Bus clock pin: period of 8 pclk, high and low for 4 each
  always @(posedge pclk) begin
    ck_cnt <= ck_run ? ck_cnt + 3'h1 : 3'h0;
    external_bus_clock <= ck_run & ck_cnt[2];
  end

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input rit_word_t exp, input rit_word_t got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input rit_addr_t a, input rit_word_t d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input rit_addr_t a, input rit_byte_t v, input rit_byte_t k);
    apb(1'b1, a, {16'h0000, k, v}, 4'hF);
  endtask : wr

  task automatic rdchk(input string what, input rit_addr_t a, input rit_word_t exp);
    apb(1'b0, a, 32'h00000000, 4'h0);
    chk(what, exp, rd);
  endtask : rdchk

  task automatic wait_pulse(output int n);
    n = 0;
    @(posedge pclk);
    while (refresh_start !== 1'b1 && n < 600) begin
      n++;
      @(posedge pclk);
    end
  endtask : wait_pulse

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rdchk("cnt", `RIT_OFS_CNT, 32'h0);
    rdchk("cor", `RIT_OFS_COR, 32'h0);
    // Counter and constant both zero after reset: that equality is one match event
    rdchk("csr", `RIT_OFS_CSR, 32'h80);
    rdchk("ist", `RIT_OFS_IST, 32'h1);
    apb(1'b0, 12'h020, 32'h0, 4'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
  endtask : t_reset

  task automatic t_keys();
    wr(`RIT_OFS_COR, 8'h33, 8'h5A);
    rdchk("cor_badkey", `RIT_OFS_COR, 32'h0);
    apb(1'b1, `RIT_OFS_COR, {16'h0, `RIT_WRITE_KEY, 8'h33}, 4'h1);
    rdchk("cor_bytewr", `RIT_OFS_COR, 32'h0);
    wr(`RIT_OFS_COR, 8'h33, `RIT_WRITE_KEY);
    rdchk("cor_keyed", `RIT_OFS_COR, 32'h33);
    wr(`RIT_OFS_CNT, 8'h40, `RIT_WRITE_KEY);
    rdchk("cnt_keyed", `RIT_OFS_CNT, 32'h40);
    wr(`RIT_OFS_CNT, 8'h11, 8'h00);
    rdchk("cnt_badkey", `RIT_OFS_CNT, 32'h40);
  endtask : t_keys

  task automatic t_match();
    int n;
    wr(`RIT_OFS_COR, 8'h05, `RIT_WRITE_KEY);
    wr(`RIT_OFS_CNT, 8'h00, `RIT_WRITE_KEY);
    wr(`RIT_OFS_MCR, 8'h03, 8'h00);
    wr(`RIT_OFS_IMSK, 8'h01, 8'h00);
    wr(`RIT_OFS_CSR, 8'h08, `RIT_WRITE_KEY);
    ck_run <= 1'b1;
    wait_pulse(n);
    chk("first_refresh", 32'h1, {31'h0, refresh_start});
    wait_pulse(n);
    chk("match_period", 32'd159, n);
    repeat (3) @(posedge pclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    rdchk("csr_flag", `RIT_OFS_CSR, 32'h88);
    rdchk("ist_both", `RIT_OFS_IST, 32'h3);
    apb(1'b0, `RIT_OFS_CNT, 32'h0, 4'h0);
    chk("cnt_bound", 32'h1, {31'h0, rd <= 32'h5});
    wr(`RIT_OFS_IMSK, 8'h00, 8'h00);
    repeat (3) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`RIT_OFS_CSR, 8'h00, `RIT_WRITE_KEY);
    ck_run <= 1'b0;
    repeat (200) @(posedge pclk);
    wr(`RIT_OFS_IST, 8'h03, 8'h00);
    rdchk("ist_clear", `RIT_OFS_IST, 32'h0);
    rdchk("csr_stop", `RIT_OFS_CSR, 32'h0);
  endtask : t_match

  task automatic t_nocbr();
    int k;
    k = 0;
    wr(`RIT_OFS_MCR, 8'h01, 8'h00);
    wr(`RIT_OFS_CSR, 8'h08, `RIT_WRITE_KEY);
    ck_run <= 1'b1;
    repeat (400) begin
      @(posedge pclk);
      if (refresh_start === 1'b1) k++;
    end
    chk("no_refresh", 32'h0, k);
    rdchk("ist_match", `RIT_OFS_IST, 32'h1);
    ck_run <= 1'b0;
  endtask : t_nocbr

  task automatic t_div16();
    int n;
    wr(`RIT_OFS_COR, 8'h03, `RIT_WRITE_KEY);
    wr(`RIT_OFS_CNT, 8'h00, `RIT_WRITE_KEY);
    wr(`RIT_OFS_MCR, 8'h03, 8'h00);
    wr(`RIT_OFS_CSR, 8'h10, `RIT_WRITE_KEY);
    ck_run <= 1'b1;
    wait_pulse(n);
    chk("div16_first", 32'h1, {31'h0, refresh_start});
    wait_pulse(n);
    chk("div16_period", 32'd383, n);
    ck_run <= 1'b0;
    wr(`RIT_OFS_CSR, 8'h08, `RIT_WRITE_KEY);
  endtask : t_div16

  task automatic t_standby();
    wr(`RIT_OFS_COR, 8'hFF, `RIT_WRITE_KEY);
    wr(`RIT_OFS_CNT, 8'h00, `RIT_WRITE_KEY);
    ck_run <= 1'b1;
    repeat (100) @(posedge pclk);
    standby <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, `RIT_OFS_CNT, 32'h0, 4'h0);
    rd2 = rd;
    repeat (200) @(posedge pclk);
    rdchk("cnt_held", `RIT_OFS_CNT, rd2);
    standby <= 1'b0;
    repeat (200) @(posedge pclk);
    apb(1'b0, `RIT_OFS_CNT, 32'h0, 4'h0);
    chk("cnt_resumes", 32'h1, {31'h0, rd > rd2});
    // Clock enable low freezes the counter; at most one tick at the boundaries
    rd2 = rd;
    pce <= 1'b0;
    repeat (300) @(posedge pclk);
    pce <= 1'b1;
    apb(1'b0, `RIT_OFS_CNT, 32'h0, 4'h0);
    chk("cnt_frozen", 32'h1, {31'h0, (rd - rd2) <= 32'h1});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ck_run <= 1'b0;
    rdchk("cnt_por", `RIT_OFS_CNT, 32'h0);
    rdchk("cor_por", `RIT_OFS_COR, 32'h0);
  endtask : t_standby

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_keys();
    t_match();
    t_nocbr();
    t_div16();
    t_standby();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end
endmodule : rit_timer_test
